// *** hw/torque_stop_consts.svh ***
// Constants of the dual channel torque stop monitor
`ifndef TORQUE_STOP_CONSTS_SVH
`define TORQUE_STOP_CONSTS_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define TS_CLK_MHZ 25
`define TS_RESP_LIMIT_US 20000
`define TS_DISC_TIME_US 10000
`define TS_SETTLE_CYC 4
`define TS_CNT_W 20

// ****************************************************************
// Fault codes reported to the fault record
// ****************************************************************
`define TS_CODE_NONE 8'h00
`define TS_CODE_FIRST 8'h48
`define TS_CODE_JOINT 8'h4C
`define TS_CODE_SECOND 8'h4D
`define TS_CODE_INTERNAL 8'h4E

// ****************************************************************
// Synchroniser lanes
// ****************************************************************
`define TS_LANES 4
`define TS_LANE_A 0
`define TS_LANE_B 1
`define TS_LANE_RUN 2
`define TS_LANE_RST 3

`endif

// *** hw/torque_stop_pkg.sv ***
// Types of the dual channel torque stop monitor
package torque_stop_pkg;

  // Monitor states
  typedef enum logic [2:0] {
    st_startup,
    st_standby,
    st_running,
    st_pending,
    st_joint_stop,
    st_first_fault,
    st_second_fault,
    st_internal_fault
  } mon_state_e;

  typedef logic [7:0] fault_code_t;

endpackage : torque_stop_pkg

// *** hw/pin_filter.sv ***
// Three stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`include "torque_stop_consts.svh"

module pin_filter (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Pin side
  input wire logic pin_i,
  // Clean level
  output logic level_o
);

  logic meta_q;
  logic sync2_q;
  logic sync3_q;

  // ****************************************************************
  // Synchroniser chain
  // ****************************************************************
  // Only the second stage reads the first one
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      meta_q <= pin_i;
      sync2_q <= meta_q;
      sync3_q <= sync2_q;
    end
  end

  // A change counts once stages two and three agree; reset reads as off, the safe side
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_o <= 1'b0;
    end else if (sync2_q == sync3_q) begin
      level_o <= sync3_q;
    end
  end

endmodule : pin_filter

// *** hw/torque_stop_monitor.sv ***
// Dual channel torque stop monitor
// Functional notes
// (RULE1) Both channels off: joint safe stop, torque off, run ignored.
// (RULE2) Channel A off alone: first channel fault, torque off.
// (RULE3) Channel B off alone: second channel fault, torque off.
// (RULE4) Torque is off within 20 ms of any channel going off.
// (RULE5) Joint stop clears on reset command with both channels on, then standby.
// (RULE6) First channel fault ignores reset command; only power cycle clears it.
// (RULE7) Second channel fault ignores reset command; only power cycle clears it.
// (RULE8) Self-check fault gives internal loop fault; persisting over power-up flags abnormal.
// (RULE9) Codes 72 for first channel fault, 77 for second.
// (RULE10) Codes 76 for joint stop, 78 for internal loop fault.
// (RULE11) Both on, nothing latched: ready, code none, standby awaiting run.
// (RULE12) Latch select 1 lets joint stop clear itself; channel faults always latch.
// (RULE13) Run after reset select 1 resumes a held run command at once.
// (RULE14) Channels synchronised first; internal fault outranks all other states.
// (RULE15) Channel and internal fault latches clear only on power-on reset.
`timescale 1ns/1ns
`include "torque_stop_consts.svh"

module torque_stop_monitor
  import torque_stop_pkg::*;
#(
  parameter int DISC_CYC = `TS_DISC_TIME_US * `TS_CLK_MHZ
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Safety channels and commands from terminals
  input wire logic safety_input_a_i,
  input wire logic safety_input_b_i,
  input wire logic run_cmd_i,
  input wire logic reset_cmd_i,
  // Same domain self-check and settings
  input wire logic self_check_fault_i,
  input wire logic alarm_latch_select_i,
  input wire logic run_after_reset_select_i,
  // Status
  output logic torque_enable_o,
  output logic ready_o,
  output fault_code_t fault_code_o,
  output logic loop_abnormal_o
);

  localparam int RESP_CYC = `TS_RESP_LIMIT_US * `TS_CLK_MHZ;

  logic [`TS_LANES-1:0] pins;
  logic [`TS_LANES-1:0] clean;
  logic a_on;
  logic b_on;
  logic run_on;
  logic rst_cmd;
  logic rst_cmd_q;
  logic rst_edge;
  mon_state_e state_q;
  mon_state_e state_d;
  logic [`TS_CNT_W-1:0] cnt_q;
  logic run_armed_q;
  logic power_up_q;

  // Map each state onto its reported code
  function automatic fault_code_t code_of(input mon_state_e s);
    unique case (s)
      st_first_fault: code_of = `TS_CODE_FIRST;
      st_second_fault: code_of = `TS_CODE_SECOND;
      st_joint_stop: code_of = `TS_CODE_JOINT;
      st_internal_fault: code_of = `TS_CODE_INTERNAL;
      default: code_of = `TS_CODE_NONE;
    endcase
  endfunction : code_of

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  assign pins[`TS_LANE_A] = safety_input_a_i;
  assign pins[`TS_LANE_B] = safety_input_b_i;
  assign pins[`TS_LANE_RUN] = run_cmd_i;
  assign pins[`TS_LANE_RST] = reset_cmd_i;

  // Every terminal input crosses in before the state logic sees it
  generate
    for (genvar i = 0; i < `TS_LANES; i++) begin : g_sync
      pin_filter u_filter (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(pins[i]),
        .level_o(clean[i])
      ); // RULE14
    end
  endgenerate

  assign a_on = clean[`TS_LANE_A];
  assign b_on = clean[`TS_LANE_B];
  assign run_on = clean[`TS_LANE_RUN];
  assign rst_cmd = clean[`TS_LANE_RST];

  // Reset command acts on its rising edge only, so a held button cannot loop
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_cmd_q <= 1'b0;
    end else begin
      rst_cmd_q <= rst_cmd;
    end
  end
  assign rst_edge = rst_cmd & ~rst_cmd_q;

  // ****************************************************************
  // State decision
  // ****************************************************************
  // One channel off opens a window in which the other may follow; both off
  // within it is a joint stop. Torque is already off for the whole window.
  always_comb begin
    state_d = state_q;
    if (self_check_fault_i) begin
      state_d = st_internal_fault; // RULE8 RULE14
    end else begin
      unique case (state_q)
        st_startup: begin
          if (cnt_q == `TS_CNT_W'(`TS_SETTLE_CYC)) begin
            state_d = st_standby;
          end
        end
        st_standby, st_running: begin
          if (!a_on && !b_on) begin
            state_d = st_joint_stop; // RULE1
          end else if (!a_on || !b_on) begin
            state_d = st_pending;
          end else if (state_q == st_standby && run_on && run_armed_q) begin
            state_d = st_running; // RULE11
          end else if (state_q == st_running && !run_on) begin
            state_d = st_standby;
          end
        end
        st_pending: begin
          if (!a_on && !b_on) begin
            state_d = st_joint_stop; // RULE1
          end else if (a_on && b_on) begin
            state_d = st_standby;
          end else if (cnt_q >= `TS_CNT_W'(DISC_CYC - 1)) begin
            state_d = a_on ? st_second_fault : st_first_fault; // RULE2 RULE3
          end
        end
        st_joint_stop: begin
          if (a_on && b_on && (alarm_latch_select_i || rst_edge)) begin
            state_d = st_standby; // RULE5 RULE12
          end
        end
        // Channel and internal faults clear only through power-on reset
        st_first_fault, st_second_fault, st_internal_fault: begin
          state_d = state_q; // RULE6 RULE7 RULE15
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= st_startup;
    end else begin
      state_q <= state_d;
    end
  end

  // Settle and discrepancy counter, restarted on each state change
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else if (state_d != state_q) begin
      cnt_q <= '0;
    end else if (state_q == st_startup || state_q == st_pending) begin
      cnt_q <= cnt_q + `TS_CNT_W'(1);
    end
  end

  // ****************************************************************
  // Run arming
  // ****************************************************************
  // A run held through a stop needs a release first, unless resume is selected and a reset command or power-on reset ends the stop
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_armed_q <= 1'b0;
    end else if (state_q == st_joint_stop && state_d == st_standby) begin
      run_armed_q <= run_after_reset_select_i && rst_edge; // RULE13
    end else if (state_q == st_startup) begin
      run_armed_q <= run_after_reset_select_i; // RULE13
    end else if (!run_on) begin
      run_armed_q <= 1'b1;
    end else if (state_d != st_standby && state_d != st_running) begin
      run_armed_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Torque, ready and fault code follow the next state so they change with the state register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      torque_enable_o <= 1'b0;
      ready_o <= 1'b0;
      fault_code_o <= `TS_CODE_NONE;
    end else begin
      torque_enable_o <= (state_d == st_running); // RULE4
      ready_o <= (state_d == st_standby) || (state_d == st_running); // RULE11
      fault_code_o <= code_of(state_d); // RULE9 RULE10
    end
  end

  // A self-check fault already present at power-up survived the power cycle
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_up_q <= 1'b1;
      loop_abnormal_o <= 1'b0;
    end else begin
      power_up_q <= 1'b0;
      if (power_up_q && self_check_fault_i) begin
        loop_abnormal_o <= 1'b1; // RULE8
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_joint_entry: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE1
    (state_q inside {st_standby, st_running, st_pending}) && !a_on && !b_on
      && !self_check_fault_i |=> state_q == st_joint_stop && !torque_enable_o)
    else $error("Both channels off did not give joint stop");

  a_torque_off_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE2
    $fell(a_on) |=> !torque_enable_o)
    else $error("Torque still on after channel A went off");

  a_torque_off_b: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE3
    $fell(b_on) |=> !torque_enable_o)
    else $error("Torque still on after channel B went off");

  a_window_bound: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE4
    state_q == st_pending |-> !torque_enable_o && cnt_q < `TS_CNT_W'(DISC_CYC)
      && DISC_CYC < RESP_CYC)
    else $error("Discrepancy window exceeds the response limit");

  a_joint_latched: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE5
    state_q == st_joint_stop && !alarm_latch_select_i && !rst_edge
      |=> state_q != st_standby)
    else $error("Latched joint stop cleared without reset command");

  a_first_sticky: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE6
    state_q == st_first_fault |=> state_q inside {st_first_fault, st_internal_fault})
    else $error("First channel fault left without power cycle");

  a_second_sticky: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE7
    state_q == st_second_fault && rst_edge |=> state_q != st_standby)
    else $error("Second channel fault cleared by reset command");

  a_internal_first: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE14
    self_check_fault_i |=> state_q == st_internal_fault
      && fault_code_o == `TS_CODE_INTERNAL)
    else $error("Self-check fault did not win");

  a_channel_codes: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE9
    (state_q == st_first_fault |-> fault_code_o == `TS_CODE_FIRST)
      and (state_q == st_second_fault |-> fault_code_o == `TS_CODE_SECOND))
    else $error("Wrong channel fault code");

  a_joint_code: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE10
    state_q == st_joint_stop |-> fault_code_o == `TS_CODE_JOINT && !ready_o)
    else $error("Wrong joint stop code");

  a_ready_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE11
    state_q == st_standby |-> ready_o && fault_code_o == `TS_CODE_NONE)
    else $error("Standby not reported as ready");

  a_joint_auto: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE12
    state_q == st_joint_stop && alarm_latch_select_i && a_on && b_on
      && !self_check_fault_i |=> state_q == st_standby)
    else $error("Unlatched joint stop did not clear");

  a_resume_run: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE13
    state_q == st_joint_stop && rst_edge && a_on && b_on && run_after_reset_select_i
      && run_on && !self_check_fault_i
      ##1 (a_on && b_on && run_on && !self_check_fault_i)
      |=> torque_enable_o)
    else $error("Held run did not resume after reset");

endmodule : torque_stop_monitor

// *** tb/estop_source.sv ***
// Far side model: emergency switch contacts and run/reset command sources
`timescale 1ns/1ns

module estop_source (
  // Clock
  input wire logic sys_clk_i,
  // Requests from the bench
  input wire logic press_a_i,
  input wire logic press_b_i,
  input wire logic run_req_i,
  input wire logic reset_req_i,
  // Terminal levels
  output logic contact_a_o,
  output logic contact_b_o,
  output logic run_o,
  output logic reset_o
);
  logic [1:0] hold_q = 2'h0;

  // Normally closed contacts: pressing opens them and the channel reads off
  assign contact_a_o = !press_a_i;
  assign contact_b_o = !press_b_i;
  assign run_o = run_req_i;

  // Stretch a reset request to 3 cycles so the pin filter cannot swallow it
  always @(posedge sys_clk_i) begin
    if (reset_req_i) begin
      hold_q <= 2'h3;
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end
  end
  assign reset_o = (hold_q != 2'h0);
endmodule : estop_source

// *** tb/testbench.sv ***
// Self-checking bench of the dual channel torque stop monitor
`timescale 1ns/1ns

module testbench;
  import torque_stop_pkg::*;
  localparam int DISC = 20;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic press_a = 1'b0;
  logic press_b = 1'b0;
  logic run_req = 1'b0;
  logic reset_req = 1'b0;
  logic self_check = 1'b0;
  logic latch_sel = 1'b0;
  logic resume_sel = 1'b0;
  logic pin_a, pin_b, pin_run, pin_rst, torque, ready, abnormal;
  fault_code_t code;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  int m_st = 0; // Model: 0 standby, 1 running, 2 joint, 3 first, 4 second, 5 internal
  int seed_v;

  // ****************************************
  // Clock, far side and design
  // ****************************************
  always #20 sys_clk_i = !sys_clk_i;

  estop_source far (.sys_clk_i(sys_clk_i), .press_a_i(press_a), .press_b_i(press_b),
    .run_req_i(run_req), .reset_req_i(reset_req), .contact_a_o(pin_a),
    .contact_b_o(pin_b), .run_o(pin_run), .reset_o(pin_rst));

  torque_stop_monitor #(.DISC_CYC(DISC)) dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .safety_input_a_i(pin_a), .safety_input_b_i(pin_b), .run_cmd_i(pin_run),
    .reset_cmd_i(pin_rst), .self_check_fault_i(self_check),
    .alarm_latch_select_i(latch_sel), .run_after_reset_select_i(resume_sel),
    .torque_enable_o(torque), .ready_o(ready), .fault_code_o(code),
    .loop_abnormal_o(abnormal));

  // Hang guard: the whole sequence needs far fewer cycles than this
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch = n_mismatch + 1;
      complete_run();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : tick

  task automatic chk_bit(input string what, input logic exp_v, input logic got_v);
    compares++;
    if (got_v !== exp_v) begin
      n_mismatch++;
      $display("unexpected %s expected %b seen %b", what, exp_v, got_v);
    end
  endtask : chk_bit

  task automatic chk_code(input string what, input fault_code_t exp_v, input fault_code_t got_v);
    compares++;
    if (got_v !== exp_v) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp_v, got_v);
    end
  endtask : chk_code

  // Outputs follow the model state: codes 76, 72, 77 and 78 for the stop states
  task automatic check_model();
    fault_code_t exp_c;
    case (m_st)
      2: exp_c = 8'h4C;
      3: exp_c = 8'h48;
      4: exp_c = 8'h4D;
      5: exp_c = 8'h4E;
      default: exp_c = 8'h00;
    endcase
    chk_bit("torque_enable", m_st == 1, torque);
    chk_bit("ready", m_st <= 1, ready);
    chk_code("fault_code", exp_c, code);
  endtask : check_model

  task automatic go_run();
    @(posedge sys_clk_i);
    run_req <= 1'b1;
    tick(10);
    m_st = 1;
    check_model();
  endtask : go_run

  task automatic set_pins(input logic a, input logic b, input logic r);
    @(posedge sys_clk_i);
    press_a <= a;
    press_b <= b;
    run_req <= r;
  endtask : set_pins

  // Open contacts; torque must drop long before the response limit
  task automatic drop(input logic a, input logic b, input int st);
    tick(1 + $urandom_range(3));
    press_a <= a;
    press_b <= b;
    tick(8);
    chk_bit("torque_enable", 1'b0, torque);
    tick(2 * DISC);
    m_st = st;
    check_model();
  endtask : drop

  task automatic pulse_reset();
    @(posedge sys_clk_i);
    reset_req <= 1'b1;
    @(posedge sys_clk_i);
    reset_req <= 1'b0;
    tick(12);
  endtask : pulse_reset

  task automatic power_cycle();
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    tick(2);
    rst_n_i <= 1'b1;
    tick(14);
  endtask : power_cycle

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed_v = $urandom(31440);
    tick(2);
    rst_n_i <= 1'b1;
    tick(14);
    check_model();
    go_run();
    drop(1'b1, 1'b1, 2);
    run_req <= 1'($urandom_range(1));
    pulse_reset();
    check_model();
    set_pins(1'b0, 1'b0, 1'b1);
    tick(10);
    pulse_reset();
    m_st = 0;
    check_model();
    set_pins(1'b0, 1'b0, 1'b0);
    tick(8);
    go_run();
    // Held run resumes at once when resume is selected
    resume_sel <= 1'b1;
    drop(1'b1, 1'b1, 2);
    set_pins(1'b0, 1'b0, 1'b1);
    tick(10);
    pulse_reset();
    m_st = 1;
    check_model();
    resume_sel <= 1'b0;
    // Joint stop without latch clears once both channels return
    latch_sel <= 1'b1;
    drop(1'b1, 1'b1, 2);
    set_pins(1'b0, 1'b0, 1'b1);
    tick(12);
    m_st = 0;
    check_model();
    // Single channel faults latch whatever the latch select says
    for (int k = 0; k < 2; k++) begin
      latch_sel <= k[0];
      set_pins(1'b0, 1'b0, 1'b0);
      tick(8);
      go_run();
      drop(k == 0, k == 1, 3 + k);
      set_pins(1'b0, 1'b0, 1'b1);
      tick(10);
      pulse_reset();
      check_model();
      set_pins(1'b0, 1'b0, 1'b0);
      power_cycle();
      m_st = 0;
      check_model();
    end
    // Self-check fault coinciding with a channel drop
    go_run();
    @(posedge sys_clk_i);
    self_check <= 1'b1;
    press_a <= 1'b1;
    tick(3);
    m_st = 5;
    check_model();
    set_pins(1'b0, 1'b0, 1'b0);
    pulse_reset();
    tick(2 * DISC);
    check_model();
    chk_bit("loop_abnormal", 1'b0, abnormal);
    power_cycle();
    check_model();
    chk_bit("loop_abnormal", 1'b1, abnormal);
    self_check <= 1'b0;
    power_cycle();
    m_st = 0;
    check_model();
    chk_bit("loop_abnormal", 1'b0, abnormal);
    complete_run();
  end
endmodule : testbench
